// ===== rtl/switch_ctrl_port.sv
`timescale 1ns/1ps
// Summary of operation
// - Input bits are sampled only while the active-low select is low.
// - Each input bit is taken on a falling edge of the serial clock.
// - A word is exactly 24 bits and bits after the 24th are ignored.
// - The shifted word is captured into the holding register when select rises.
// - With the strobe low the held word also reaches the switches at select rise.
// - With the strobe in use the switches update on the strobe's falling edge.
// - The serial output changes after each rising serial clock edge while select is low.
// - An interface-select input picks serial or five-bit parallel control.
// - The strobe pin is the latch in serial mode and parallel bit zero otherwise.
module switch_ctrl_port
  import sw_ctrl_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        par_mode,
  input  wire logic                        sclk,
  input  wire logic                        sdi,
  input  wire logic                        cs_n,
  input  wire logic                        latch_n,
  output logic                             sdo,
  output logic                             sdo_oe,
  output logic      [sw_ctrl_pkg::WORD_BITS-1:0] switches,
  output logic      [sw_ctrl_pkg::PAR_BITS-1:0]  par_ctrl,
  output logic                             word_err
);
  import sw_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Synchronisers reset to the idle pin levels, select high, so that no
  // false select edge and no stray capture follows reset
  logic [4:0] pins_s;
  pin_sync #(.W(5), .RST_VAL(PIN_RST)) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .d       ({par_mode, sclk, sdi, cs_n, latch_n}),
    .q       (pins_s)
  );
  logic mode_s, sclk_s, sdi_s, cs_s, latch_s;
  assign {mode_s, sclk_s, sdi_s, cs_s, latch_s} = pins_s;

  // ----------------------------------------------------------------
  // Edge detection and shift state
  // ----------------------------------------------------------------
  logic                 sclk_d_r, cs_d_r, latch_d_r;
  logic [WORD_BITS-1:0] shift_r, shift_nxt;
  logic [WORD_BITS-1:0] hold_r, hold_nxt;
  logic [WORD_BITS-1:0] sw_r, sw_nxt;
  logic [4:0]           cnt_r, cnt_nxt;
  logic                 sdo_r, sdo_nxt, oe_r, oe_nxt, err_r, err_nxt;
  logic [PAR_BITS-1:0]  par_r, par_nxt;
  logic                 pend_r, pend_nxt;

  // ----------------------------------------------------------------
  // Edge helpers
  // ----------------------------------------------------------------
  // Edges are seen in the same cycle that the synchronised level changes
  function automatic logic went_high(input logic prev, input logic now);
    return ~prev & now;
  endfunction

  function automatic logic went_low(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  logic sclk_fall, sclk_rise, cs_rise, latch_fall, ser;
  assign ser        = !mode_s;
  assign sclk_fall  = went_low(sclk_d_r, sclk_s);
  assign sclk_rise  = went_high(sclk_d_r, sclk_s);
  assign cs_rise    = went_high(cs_d_r, cs_s);
  assign latch_fall = went_low(latch_d_r, latch_s);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    shift_nxt = shift_r;
    hold_nxt  = hold_r;
    sw_nxt    = sw_r;
    cnt_nxt   = cnt_r;
    sdo_nxt   = sdo_r;
    oe_nxt    = ser & ~cs_s;
    err_nxt   = err_r;
    par_nxt   = par_r;
    pend_nxt  = pend_r;
    if (!ser) begin
      // Parallel pins drive the controls directly; strobe pin is bit zero
      par_nxt  = {cs_s, sdi_s, 1'b0, sclk_s, latch_s};
      cnt_nxt  = CNT_RST;
      pend_nxt = 1'b0;
    end else begin
      if (!cs_s && sclk_fall && cnt_r != CNT_FULL) begin
        shift_nxt = {shift_r[WORD_BITS-2:0], sdi_s};
        cnt_nxt   = cnt_r + 5'h01;
      end
      if (!cs_s && sclk_rise) begin
        sdo_nxt = shift_r[WORD_BITS-1];
      end
      if (cs_rise) begin
        // A short or overlong word is still captured; word_err flags only a short word
        hold_nxt = shift_r;
        err_nxt  = (cnt_r != CNT_FULL);
        cnt_nxt  = CNT_RST;
        if (!latch_s) begin
          sw_nxt   = shift_r;
          pend_nxt = 1'b0;
        end else begin
          pend_nxt = 1'b1;
        end
      end
      // A strobe fall that meets select rise applies the new word, not the old
      if (latch_fall && (pend_r || cs_rise)) begin
        sw_nxt   = cs_rise ? shift_r : hold_r;
        pend_nxt = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_r  <= 1'b0;
      cs_d_r    <= 1'b1;
      latch_d_r <= 1'b0;
      shift_r   <= SWITCH_RST;
      hold_r    <= SWITCH_RST;
      sw_r      <= SWITCH_RST;
      cnt_r     <= CNT_RST;
      sdo_r     <= 1'b0;
      oe_r      <= 1'b0;
      err_r     <= 1'b0;
      par_r     <= '0;
      pend_r    <= 1'b0;
    end else begin
      sclk_d_r  <= sclk_s;
      cs_d_r    <= cs_s;
      latch_d_r <= latch_s;
      shift_r   <= shift_nxt;
      hold_r    <= hold_nxt;
      sw_r      <= sw_nxt;
      cnt_r     <= cnt_nxt;
      sdo_r     <= sdo_nxt;
      oe_r      <= oe_nxt;
      err_r     <= err_nxt;
      par_r     <= par_nxt;
      pend_r    <= pend_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sdo      = sdo_r;
  assign sdo_oe   = oe_r;
  assign switches = sw_r;
  assign par_ctrl = par_r;
  assign word_err = err_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_word_end;
    ser && cs_rise && !latch_s;
  endsequence

  sequence s_deferred_end;
    ser && cs_rise && latch_s;
  endsequence

  // Serial capture path
  chk_count_limit: assert property (@(posedge sys_clk) disable iff (!rstn)
    cnt_r <= CNT_FULL) else $error("bit count beyond word length");
  chk_no_shift_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ser && cs_s && $past(cs_s) && !cs_rise) |=> shift_r == $past(shift_r))
    else $error("shift while deselected");
  chk_shift_fall: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ser && !cs_s && sclk_fall && cnt_r < CNT_FULL) |=> shift_r[0] == $past(sdi_s))
    else $error("bit not taken on falling edge");
  chk_no_shift_full: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ser && cnt_r == CNT_FULL) |=> shift_r == $past(shift_r))
    else $error("bit taken beyond word length");
  chk_count_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ser && cs_rise) |=> cnt_r == CNT_RST) else $error("bit count not cleared");
  chk_err_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ser && cs_rise) |=> word_err == ($past(cnt_r) != CNT_FULL))
    else $error("word length flag wrong");
  chk_hold_cap: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ser && cs_rise) |=> hold_r == $past(shift_r)) else $error("word not held");

  // Switch update path
  chk_apply_cs: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_word_end |=> sw_r == $past(shift_r)) else $error("switches not updated at select rise");
  chk_pend_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_deferred_end |=> pend_r && $stable(sw_r)) else $error("deferred word applied early");
  chk_apply_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ser && pend_r && latch_fall && !cs_rise) |=> sw_r == hold_r && !pend_r)
    else $error("switches not updated at strobe fall");
  chk_sw_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ser && !cs_rise && !latch_fall) |=> $stable(sw_r)) else $error("spurious switch update");

  // Serial output
  chk_sdo_rise: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ser && !cs_s && sclk_rise) |=> sdo == $past(shift_r[WORD_BITS-1]))
    else $error("serial output not updated");
  chk_sdo_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(ser && !cs_s && sclk_rise) |=> $stable(sdo))
    else $error("serial output moved off edge");
  chk_oe_select: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ser && !cs_s) |=> sdo_oe) else $error("serial output not driven");
  chk_oe_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!ser || cs_s) |=> !sdo_oe) else $error("serial output driven while idle");

  // Parallel mode
  chk_par_bit0: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!ser) |=> par_ctrl[0] == $past(latch_s)) else $error("parallel bit zero wrong");
  chk_par_frozen: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!ser) |=> $stable(sw_r)) else $error("switches moved in parallel mode");
endmodule // switch_ctrl_port

// ===== rtl/sw_ctrl_pkg.sv
package sw_ctrl_pkg;
  localparam int WORD_BITS     = 24;
  localparam int PAR_BITS      = 5;
  localparam int CLK_MHZ       = 40;
  // Longest switch update latency at the lower logic supply, in ns
  localparam int UPDATE_MAX_NS = 145;
  // Longest time rounds down, never below one cycle
  localparam int UPDATE_CYC_RAW = (UPDATE_MAX_NS * CLK_MHZ) / 1000;
  localparam int UPDATE_CYC     = (UPDATE_CYC_RAW < 1) ? 1 : UPDATE_CYC_RAW;
  localparam logic [23:0] SWITCH_RST = 24'h000000;
  localparam logic [4:0]  CNT_RST    = 5'h00;
  localparam logic [4:0]  CNT_FULL   = 5'h18;
  // Synchroniser reset, idle pin levels: select high, all other pins low
  localparam logic [4:0]  PIN_RST    = 5'h02;
endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // pin_sync

// ===== sim/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [23:0] word,
  input  wire logic [4:0]  nbits,
  input  wire logic        sdo,
  output logic             sclk,
  output logic             sdi,
  output logic             cs_n,
  output logic             busy,
  output logic [23:0]      rx
);
  logic [23:0] w;
  // Clock stands low outside frames; released data line shows its inverse
  initial begin
    sclk = 1'b0;
    sdi  = 1'b0;
    cs_n = 1'b1;
    busy = 1'b0;
    rx   = 24'h000000;
    forever begin
      @(posedge sys_clk);
      if (go) begin
        busy <= 1'b1;
        cs_n <= 1'b0;
        w = word;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < nbits; i++) begin
          sclk <= 1'b1;
          sdi  <= w[23];
          w = w << 1;
          repeat (4) @(posedge sys_clk);
          sclk <= 1'b0;
          repeat (2) @(posedge sys_clk);
          rx <= {rx[22:0], sdo};
          repeat (2) @(posedge sys_clk);
        end
        cs_n <= 1'b1;
        sdi  <= ~sdi;
        busy <= 1'b0;
        repeat (2) @(posedge sys_clk);
      end
    end
  end
endmodule  // host_model

// ===== sim/serial_switch_control_port_test.sv
`timescale 1ns/1ps
module serial_switch_control_port_test;
  import sw_ctrl_pkg::*;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
  logic        sys_clk, rstn, par_mode, latch_n, go, sclk, sdi, cs_n, busy, sdo, sdo_oe, word_err;
  logic [23:0] word, rx, switches;
  logic [4:0]  nbits, par_ctrl;
  int          errors = 0;
  int          tests_run = 0;
  switch_ctrl_port DUT (.sys_clk(sys_clk), .rstn(rstn), .par_mode(par_mode), .sclk(sclk),
    .sdi(sdi), .cs_n(cs_n), .latch_n(latch_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .switches(switches), .par_ctrl(par_ctrl), .word_err(word_err));
  host_model host (.sys_clk(sys_clk), .go(go), .word(word), .nbits(nbits), .sdo(sdo),
    .sclk(sclk), .sdi(sdi), .cs_n(cs_n), .busy(busy), .rx(rx));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task finish_test;
    $display("Counts: %0d errors, %0d tests_run", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Returns UPDATE_CYC edges after select rises, inside the latency bound
  task frame(input logic [23:0] v, input logic [4:0] n);
    int k;
    @(posedge sys_clk);
    word  <= v;
    nbits <= n;
    go    <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    k = 0;
    repeat (2) @(posedge sys_clk);
    while (busy && k < 1000) begin
      @(posedge sys_clk);
      k++;
      if (k == 2) `CHK(sdo_oe, 1'b1)
    end
    if (k == 1000) begin
      errors++;
      finish_test;
    end
    repeat (UPDATE_CYC - 1) @(posedge sys_clk);
    #1;
  endtask
  task t_direct;
    frame(24'h5A3C96, 5'h18);
    `CHK(switches, 24'h5A3C96)
    `CHK(word_err, 1'b0)
    `CHK(sdo_oe, 1'b0)
    $display("direct update test done");
  endtask
  task t_latch;
    @(posedge sys_clk);
    latch_n <= 1'b1;
    frame(24'hC3A517, 5'h18);
    `CHK(switches, 24'h5A3C96)
    `CHK(rx, 24'h5A3C96)
    @(posedge sys_clk);
    latch_n <= 1'b0;
    repeat (UPDATE_CYC) @(posedge sys_clk);
    #1;
    `CHK(switches, 24'hC3A517)
    $display("strobe update test done");
  endtask
  task t_count;
    frame(24'h0F0F0F, 5'h17);
    `CHK(word_err, 1'b1)
    frame(24'h81FF42, 5'h19);
    `CHK(switches, 24'h81FF42)
    `CHK(word_err, 1'b0)
    $display("bit count test done");
  endtask
  task t_par;
    @(posedge sys_clk);
    par_mode <= 1'b1;
    latch_n  <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK(par_ctrl, {1'b1, sdi, 3'h1})
    `CHK(sdo_oe, 1'b0)
    @(posedge sys_clk);
    latch_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK(par_ctrl, {1'b1, sdi, 3'h0})
    `CHK(switches, 24'h81FF42)
    $display("parallel mode test done");
  endtask
  initial begin
    rstn     = 1'b0;
    par_mode = 1'b0;
    latch_n  = 1'b0;
    go       = 1'b0;
    word     = 24'h000000;
    nbits    = 5'h00;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(switches, SWITCH_RST)
    `CHK(word_err, 1'b0)
    `CHK(sdo_oe, 1'b0)
    t_direct;
    t_latch;
    t_count;
    t_par;
    finish_test;
  end
endmodule  // serial_switch_control_port_test
